/* mcsd_decoder.v */
`timescale 1ns/100ps
`include "mcsd_defs.vh"
// Contract
// - ROM select active when address page is at or below the ROM limit.
// - RAM select active when page at most RAM upper and above RAM lower.
// - When both ranges hit and setup bit D5 is clear, only the ROM select is asserted.
// - Reset loads all three limit registers with all ones.
// - Setup bit D5 forces the ROM select inactive, letting RAM overlay.
// - ROM range lower end is fixed at address zero.
// - Decoder uses CPU A18 before its mux with the timer output.
// - Limit and setup registers sit at consecutive I/O ports EA..ED.
module mcsd_decoder #(
	parameter AW = 20,
	parameter IOAW = 8,
	parameter DW = 8
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_b_i,
	// CPU memory address, with A18 as driven by the core
	input wire [AW-1:0] cpu_addr_i,
	input wire mem_req_i,
	// I/O register port
	input wire [IOAW-1:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [DW-1:0] io_wdata_i,
	output reg [DW-1:0] io_rdata_o,
	output wire io_hit_o,
	// Memory device selects
	output wire rom_select_n_o,
	output wire ram_select_n_o,
	// Setup register contents for other blocks
	output wire [DW-1:0] system_setup_o
);
	reg [7:0] ram_upper_limit;
	reg [7:0] ram_lower_limit;
	reg [7:0] rom_upper_limit;
	reg [DW-1:0] system_setup;
	reg [DW-1:0] next_rdata;
	wire sel_ram_upper;
	wire sel_ram_lower;
	wire sel_rom_upper;
	wire sel_setup;
	wire [7:0] page;
	wire rom_hit;
	wire ram_hit;
	wire rom_sel;
	wire ram_sel;

	// The page is taken from the core address; A18 is the core's own bit
	// and never the pin shared with the timer output.
	assign page = cpu_addr_i[`MCSD_PAGE_HI:`MCSD_PAGE_LO];

	// Register decode at the fixed port locations.
	assign sel_ram_upper = (io_addr_i == `MCSD_ADDR_RAM_UPPER);
	assign sel_ram_lower = (io_addr_i == `MCSD_ADDR_RAM_LOWER);
	assign sel_rom_upper = (io_addr_i == `MCSD_ADDR_ROM_UPPER);
	assign sel_setup = (io_addr_i == `MCSD_ADDR_SETUP);
	assign io_hit_o = sel_ram_upper | sel_ram_lower | sel_rom_upper |
		sel_setup;

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			ram_upper_limit <= `MCSD_LIMIT_RESET;
			ram_lower_limit <= `MCSD_LIMIT_RESET;
			rom_upper_limit <= `MCSD_LIMIT_RESET;
			system_setup <= `MCSD_SETUP_RESET;
		end else if (io_wr_i) begin
			if (sel_ram_upper) begin
				ram_upper_limit <= io_wdata_i[7:0];
			end
			if (sel_ram_lower) begin
				ram_lower_limit <= io_wdata_i[7:0];
			end
			if (sel_rom_upper) begin
				rom_upper_limit <= io_wdata_i[7:0];
			end
			if (sel_setup) begin
				system_setup <= io_wdata_i;
			end
		end
	end

	always @* begin
		next_rdata = {DW{1'b0}};
		if (sel_ram_upper) begin
			next_rdata[7:0] = ram_upper_limit;
		end else if (sel_ram_lower) begin
			next_rdata[7:0] = ram_lower_limit;
		end else if (sel_rom_upper) begin
			next_rdata[7:0] = rom_upper_limit;
		end else if (sel_setup) begin
			next_rdata = system_setup;
		end
	end

	// Read data is registered: it appears the cycle after the strobe and
	// holds until the next read, so slow bus cycles see a stable value.
	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			io_rdata_o <= {DW{1'b0}};
		end else if (io_rd_i) begin
			io_rdata_o <= next_rdata;
		end
	end

	// ROM window runs from page zero up to its limit; the lower bound is
	// zero, so an inclusive compare against zero is always true.
	mcsd_range_cmp #(
		.W(8),
		.LOWER_INCL(1)
	) u_rom_cmp (
		.page_i(page),
		.upper_i(rom_upper_limit),
		.lower_i(`MCSD_ROM_BASE_PAGE),
		.hit_o(rom_hit)
	);

	// RAM window has a strict lower compare.
	mcsd_range_cmp #(
		.W(8),
		.LOWER_INCL(0)
	) u_ram_cmp (
		.page_i(page),
		.upper_i(ram_upper_limit),
		.lower_i(ram_lower_limit),
		.hit_o(ram_hit)
	);

	assign rom_sel = mem_req_i && rom_hit &&
		!system_setup[`MCSD_SETUP_ROM_OFF];
	assign ram_sel = mem_req_i && ram_hit && !rom_sel;

	// Selects are combinational so they settle within the address delay.
	assign rom_select_n_o = ~rom_sel;
	assign ram_select_n_o = ~ram_sel;
	assign system_setup_o = system_setup;
endmodule // mcsd_decoder

/* mcsd_defs.vh */
`ifndef MCSD_DEFS_VH
`define MCSD_DEFS_VH

// I/O port locations of the configuration registers.
`define MCSD_ADDR_RAM_UPPER 8'hea
`define MCSD_ADDR_RAM_LOWER 8'heb
`define MCSD_ADDR_ROM_UPPER 8'hec
`define MCSD_ADDR_SETUP 8'hed

// Reset values.
`define MCSD_LIMIT_RESET 8'hff
`define MCSD_SETUP_RESET 8'h00

// Bottom page of the ROM window, fixed and not programmable.
`define MCSD_ROM_BASE_PAGE 8'h00

// Field positions.
`define MCSD_SETUP_ROM_OFF 5
`define MCSD_PAGE_HI 19
`define MCSD_PAGE_LO 12
`define MCSD_MUX_BIT 18

`endif

/* mcsd_range_cmp.v */
`timescale 1ns/100ps
// Window compare of one page number against an upper and a lower limit.
module mcsd_range_cmp #(
	parameter W = 8,
	parameter LOWER_INCL = 0
) (
	// Operands
	input wire [W-1:0] page_i,
	input wire [W-1:0] upper_i,
	input wire [W-1:0] lower_i,
	// Result
	output wire hit_o
);
	wire above_lower;

	assign above_lower = (LOWER_INCL != 0) ? (page_i >= lower_i) :
		(page_i > lower_i);
	assign hit_o = (page_i <= upper_i) && above_lower;
endmodule // mcsd_range_cmp

/* mcsd_mem_model.sv */
`timescale 1ns/100ps
// A deselected bus shows a fixed pattern, never the last driven value.
module mcsd_mem (
	input wire logic rom_n_i, ram_n_i,
	output wire logic [7:0] data_o
);
	assign data_o = !rom_n_i ? 8'h0c : !ram_n_i ? 8'h0a : 8'h55;
endmodule // mcsd_mem

/* mcsd_decoder_asserts.sv */
`timescale 1ns/100ps
module mcsd_chk (
	input logic clock_i, rst_b_i, mem_req_i, io_rd_i, io_wr_i,
	input logic io_hit_o, rom_select_n_o, ram_select_n_o,
	input logic [19:0] cpu_addr_i,
	input logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, system_setup_o
);
	logic [7:0] ru, rl, ro;
	wire [7:0] pg = cpu_addr_i[19:12];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	always @(posedge clock_i) begin
		if (!rst_b_i)
			{ru, rl, ro} <= 24'hff_ffff;
		else if (io_wr_i && io_addr_i == 8'hea)
			ru <= io_wdata_i;
		else if (io_wr_i && io_addr_i == 8'heb)
			rl <= io_wdata_i;
		else if (io_wr_i && io_addr_i == 8'hec)
			ro <= io_wdata_i;
	end
	sequence s_rd_rom;
		io_rd_i && io_addr_i == 8'hec;
	endsequence
	a_rom_range: assert property (mem_req_i && !system_setup_o[5] |->
		rom_select_n_o == (pg > ro)) else $error("bad rom");
	a_rom_off: assert property (mem_req_i && system_setup_o[5] |->
		rom_select_n_o) else $error("rom on");
	a_ram_range: assert property (mem_req_i && rom_select_n_o |->
		ram_select_n_o == !(pg <= ru && pg > rl)) else $error("bad ram");
	a_rom_prio: assert property (!rom_select_n_o |->
		ram_select_n_o) else $error("both on");
	a_reset_all: assert property (!$past(rst_b_i) && mem_req_i |->
		!rom_select_n_o) else $error("rom off");
	a_io_hit: assert property (io_hit_o ==
		(io_addr_i >= 8'hea && io_addr_i <= 8'hed)) else $error("bad hit");
	a_rd_back: assert property (s_rd_rom |=>
		io_rdata_o == $past(ro)) else $error("bad read");
	a_idle_off: assert property (!mem_req_i |->
		rom_select_n_o && ram_select_n_o) else $error("idle on");
endmodule // mcsd_chk
bind mcsd_decoder mcsd_chk u_chk (.*);

/* mcsd_tb.sv */
`timescale 1ns/100ps
module tb;
	logic clock_i = 0, rst_b_i = 0, mem_req_i = 0, io_wr_i = 0, io_rd_i = 0;
	logic [19:0] cpu_addr_i = 0;
	logic [7:0] io_addr_i = 0, io_wdata_i = 0, io_rdata_o, system_setup_o, p, a;
	logic [7:0] mdat;
	logic io_hit_o, rom_select_n_o, ram_select_n_o, rom, ram;
	logic [7:0] r [4] = '{8'hff, 8'hff, 8'hff, 8'h00};
	logic [15:0] cfg [6] = '{16'hec3f, 16'heb3f, 16'hea7f,
		16'he900, 16'heb10, 16'hed20};
	logic [26:0] q [$], e;
	wire [26:0] got = {rom_select_n_o, ram_select_n_o, io_hit_o, io_rdata_o,
		system_setup_o, mdat};
	int fails = 0, num_checks = 0, t;
	always #4 clock_i = ~clock_i;
	mcsd_decoder u_dut (.*);
	mcsd_mem u_mem (.rom_n_i(rom_select_n_o), .ram_n_i(ram_select_n_o),
		.data_o(mdat));
	// Expected selects, port hit, read data, setup copy and memory data.
	task note(input logic [7:0] d);
		rom = mem_req_i && !r[3][5] && cpu_addr_i[19:12] <= r[2];
		ram = mem_req_i && !rom && cpu_addr_i[19:12] <= r[0] &&
			cpu_addr_i[19:12] > r[1];
		q.push_back({~rom, ~ram, io_addr_i > 8'he9 && io_addr_i < 8'hee, d,
			r[3], (rom ? 8'h0c : (ram ? 8'h0a : 8'h55))});
	endtask
	// A memory access stands at the release edge so the reset state is seen.
	task leave_reset;
		{rst_b_i, mem_req_i, cpu_addr_i} = {2'b11, 20'($urandom)};
		r = '{8'hff, 8'hff, 8'hff, 8'h00};
		note(8'h00);
	endtask
	task reset_mid;
		@(negedge clock_i);
		{rst_b_i, io_rd_i, io_addr_i} = 10'h000;
		repeat (3) @(negedge clock_i);
		leave_reset;
	endtask
	task wr(input logic [15:0] c);
		@(negedge clock_i);
		{io_rd_i, io_wr_i, io_addr_i, io_wdata_i} = {2'b01, c};
		if (c[15:8] > 8'he9)
			r[c[15:8] - 8'hea] = c[7:0];
		@(negedge clock_i);
		io_wr_i = 0;
	endtask
	// Half the pages sit on a limit or one either side of it.
	task op;
		@(negedge clock_i);
		p = $urandom % 2 ? $urandom : r[$urandom % 3] + $urandom % 3 - 1;
		a = 8'he9 + $urandom % 6;
		mem_req_i = $urandom % 4 != 0;
		{cpu_addr_i, io_addr_i, io_rd_i} = {p, 12'($urandom), a, 1'b1};
		note(a > 8'he9 && a < 8'hee ? r[a - 8'hea] : 8'h00);
	endtask
	always @(posedge clock_i) begin
		#1;
		if (q.size()) begin
			e = q.pop_front();
			num_checks++;
			if (got !== e) begin
				$display("mismatch %0t got %h want %h", $time, got, e);
				fails++;
			end
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(34));
		repeat (20) @(negedge clock_i);
		leave_reset;
		for (t = 0; t < 8; t++) begin
			if (t == 7)
				reset_mid;
			else if (t > 0)
				wr(cfg[t - 1]);
			repeat (40) op;
			$display("test %0d done", t);
		end
		@(negedge clock_i);
		if (q.size() != 0) begin
			$display("mismatch %0t %0d results never seen", $time, q.size());
			fails++;
		end
		report_and_stop;
	end
endmodule // tb
